// file: verification/query_issuer.sv
// Partner model: execution path that issues identification queries
module query_issuer (
  input  wire logic        clk,
  output logic             query_valid,
  output logic      [31:0] query_leaf,
  output logic      [31:0] query_index,
  output logic             misc_wr,
  output logic      [31:0] misc_wdata
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    query_valid = 1'b0;
    query_leaf  = 32'h0;
    query_index = 32'h0;
    misc_wr     = 1'b0;
    misc_wdata  = 32'h0;
  end
  // ****************************************
  // Requests, all launched at the falling edge
  // ****************************************
  task automatic put_query(input logic [31:0] leaf, input logic [31:0] idx);
    @(negedge clk);
    query_valid = 1'b1;
    misc_wr     = 1'b0;
    query_leaf  = leaf;
    query_index = idx;
  endtask
  task automatic put_misc(input logic [31:0] data);
    @(negedge clk);
    query_valid = 1'b0;
    misc_wr     = 1'b1;
    misc_wdata  = data;
  endtask
  // Released lines flip so a stale value never looks like a request
  task automatic put_idle();
    @(negedge clk);
    query_valid = 1'b0;
    misc_wr     = 1'b0;
    query_leaf  = ~query_leaf;
    query_index = ~query_index;
    misc_wdata  = ~misc_wdata;
  endtask
endmodule // query_issuer

// file: verification/test_cache_parameter_enumeration.sv
// Self-checking testbench of the cache parameter enumeration block
module test_cache_parameter_enumeration;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk, reset_n, clk_en, q_valid, m_wr, r_valid, r_hidden;
  logic [31:0] q_leaf, q_index, m_wdata, r_a, r_b, r_c, r_d, m_rdata;
  int          fails, total_checks;
  logic [31:0] idx_list [6] = '{32'h4, 32'hFFFFFFFF, 32'h0, 32'h1, 32'h2,
                                32'h3};
  logic [31:0] exp_a [6] = '{32'h0, 32'h0, 32'h04004121, 32'h04004122,
                             32'h04004143, 32'h0400C363};
  logic [31:0] exp_b [6] = '{32'h0, 32'h0, 32'h01C0003F, 32'h01C0003F,
                             32'h03C0003F, 32'h03C0003F};
  logic [31:0] exp_c [6] = '{32'h0, 32'h0, 32'h3F, 32'h3F, 32'h3FF, 32'h0};
  logic [31:0] exp_sz [6] = '{32'h1, 32'h1, 32'h8000, 32'h8000,
                              32'h100000, 32'h400};
  logic [31:0] leaves [5] = '{32'h3, 32'h4, 32'h5, 32'h7FFFFFFF,
                              32'h80000000};
  initial clk = 1'b0;
  always #20 clk = ~clk;
  query_issuer i_query_issuer (.clk(clk), .query_valid(q_valid),
    .query_leaf(q_leaf), .query_index(q_index), .misc_wr(m_wr),
    .misc_wdata(m_wdata));
  cache_parameter_enumeration i_cache_parameter_enumeration (
    .CLK(clk), .RESET_N(reset_n), .CLK_EN(clk_en), .QUERY_VALID(q_valid),
    .QUERY_LEAF(q_leaf), .QUERY_INDEX(q_index), .MISC_WR(m_wr),
    .MISC_WDATA(m_wdata), .RESULT_VALID(r_valid), .RESULT_HIDDEN(r_hidden),
    .RESULT_A(r_a), .RESULT_B(r_b), .RESULT_C(r_c), .RESULT_D(r_d),
    .MISC_RDATA(m_rdata));
  // ****************************************
  // Compare and closing tasks
  // ****************************************
  task automatic chk32(input string what, input logic [31:0] exp, got);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic tally_and_finish();
    if (fails == 0 && total_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_reset();
    reset_n = 1'b0;
    repeat (6) @(negedge clk);
    reset_n = 1'b1;
    chk32("outputs after reset", 32'h0, {30'h0, r_valid, r_hidden} | r_a
          | r_b | r_c | r_d | m_rdata);
  endtask
  task automatic chk_words(input int j);
    chk32("valid", 32'h1, {31'h0, r_valid});
    chk32("first word", exp_a[j], r_a);
    chk32("second word", exp_b[j], r_b);
    chk32("third word", exp_c[j], r_c);
    chk32("fourth word", 32'h0, r_d);
    chk32("capacity", exp_sz[j], (r_b[31:22] + 32'h1) * (r_b[21:12] + 32'h1)
          * (r_b[11:0] + 32'h1) * (r_c + 32'h1));
  endtask
  task automatic t_table();
    for (int k = 0; k < 6; k++) begin
      i_query_issuer.put_query(cache_enum_pkg::CACHE_LEAF, idx_list[k]);
      if (k > 0) chk_words(k - 1);
    end
    i_query_issuer.put_idle();
    chk_words(5);
    i_query_issuer.put_idle();
    chk32("valid drop", 32'h0, {31'h0, r_valid});
    chk32("held word", exp_a[5], r_a);
  endtask
  // Stalled clock enable must not let the query through
  task automatic t_clken();
    i_query_issuer.put_query(cache_enum_pkg::CACHE_LEAF, 32'h2);
    clk_en = 1'b0;
    i_query_issuer.put_idle();
    clk_en = 1'b1;
    chk32("frozen valid", 32'h0, {31'h0, r_valid});
    chk32("frozen word", exp_a[5], r_a);
  endtask
  task automatic t_leaves(input logic limit);
    logic hid;
    i_query_issuer.put_misc(limit ? 32'hFFFFFFFF : 32'hFFBFFFFF);
    i_query_issuer.put_idle();
    chk32("control", {9'h0, limit, 22'h0}, m_rdata);
    for (int k = 0; k < 6; k++) begin
      if (k < 5) i_query_issuer.put_query(leaves[k], 32'h0);
      else i_query_issuer.put_idle();
      if (k > 0) begin
        hid = limit && (leaves[k-1] > 32'h3) && (leaves[k-1] < 32'h80000000);
        chk32("hidden", {31'h0, hid}, {31'h0, r_hidden});
        chk32("leaf word", (leaves[k-1] == 32'h4 && !hid) ? exp_a[2] : 32'h0,
              r_a);
      end
    end
  endtask
  initial begin
    fails = 0;
    total_checks = 0;
    clk_en = 1'b1;
    t_reset();
    t_table();
    t_clken();
    t_leaves(1'b0);
    t_leaves(1'b1);
    t_reset();
    chk32("control after reset", 32'h0, m_rdata);
    tally_and_finish();
  end
  // Whole run is well under 200 cycles
  initial begin
    #(40 * 2000);
    fails++;
    tally_and_finish();
  end
endmodule // test_cache_parameter_enumeration

// file: verilog/cache_desc_rom.sv
// Constant table of descriptors for each implemented cache
module cache_desc_rom #(
  parameter int NUM = cache_enum_pkg::NUM_CACHES
) (
  input  wire logic [31:0] index,
  output logic      [31:0] word_a,
  output logic      [31:0] word_b,
  output logic      [31:0] word_c
);

  // ****************************************
  // Descriptor assembly
  // ****************************************
  function automatic logic [31:0] pack_a(
    input logic [4:0] ctype, input logic [2:0] lvl, input logic selfi,
    input logic fa, input logic [11:0] share, input logic [5:0] cores);
    logic [31:0] w;
    w = 32'h0000_0000;
    w[cache_enum_pkg::TYPE_LSB +: cache_enum_pkg::TYPE_W]   = ctype; // see (R2)
    w[cache_enum_pkg::LEVEL_LSB +: cache_enum_pkg::LEVEL_W] = lvl;   // see (R2)
    w[cache_enum_pkg::SELFINIT_BIT]  = selfi;                        // see (R3)
    w[cache_enum_pkg::FULLASSOC_BIT] = fa;                           // see (R3)
    w[cache_enum_pkg::SHARE_LSB +: cache_enum_pkg::SHARE_W] = share; // see (R4)
    w[cache_enum_pkg::CORES_LSB +: cache_enum_pkg::CORES_W] = cores; // see (R5)
    return w; // Bits 13:10 stay zero, see (R11)
  endfunction

  function automatic logic [31:0] pack_b(
    input logic [11:0] line, input logic [9:0] part, input logic [9:0] ways);
    return {ways, part, line}; // see (R6) see (R7) see (R8)
  endfunction

  // Geometry below is a plain default set; values are minus-one encoded
  always_comb begin
    word_a = 32'h0000_0000;
    word_b = 32'h0000_0000;
    word_c = 32'h0000_0000;
    if (index == 32'h0000_0000 && NUM > 0) begin
      word_a = pack_a(5'h01, 3'h1, 1'b1, 1'b0, 12'h001, 6'h01);
      word_b = pack_b(12'h03F, 10'h000, 10'h007);
      word_c = 32'h0000_003F; // see (R9)
    end else if (index == 32'h0000_0001 && NUM > 1) begin
      word_a = pack_a(5'h02, 3'h1, 1'b1, 1'b0, 12'h001, 6'h01);
      word_b = pack_b(12'h03F, 10'h000, 10'h007);
      word_c = 32'h0000_003F; // see (R9)
    end else if (index == 32'h0000_0002 && NUM > 2) begin
      word_a = pack_a(5'h03, 3'h2, 1'b1, 1'b0, 12'h001, 6'h01);
      word_b = pack_b(12'h03F, 10'h000, 10'h00F);
      word_c = 32'h0000_03FF; // see (R9)
    end else if (index == 32'h0000_0003 && NUM > 3) begin
      word_a = pack_a(5'h03, 3'h3, 1'b1, 1'b1, 12'h003, 6'h01);
      word_b = pack_b(12'h03F, 10'h000, 10'h00F);
      word_c = 32'h0000_0000; // see (R9)
    end
  end

endmodule // cache_desc_rom

// file: verilog/cache_enum_pkg.sv
// Package of constants for the cache parameter enumeration block
package cache_enum_pkg;

  // ****************************************
  // Query and control
  // ****************************************
  localparam logic [31:0] CACHE_LEAF        = 32'h0000_0004;
  localparam logic [31:0] LIMIT_LEAF_LOW    = 32'h0000_0003;
  localparam logic [31:0] LIMIT_LEAF_HIGH   = 32'h8000_0000;
  localparam int          LEAF_LIMIT_BIT    = 22;
  localparam logic        LEAF_LIMIT_RESET  = 1'b0;

  // ****************************************
  // First result word fields
  // ****************************************
  localparam int TYPE_LSB    = 0;
  localparam int TYPE_W      = 5;
  localparam int LEVEL_LSB   = 5;
  localparam int LEVEL_W     = 3;
  localparam int SELFINIT_BIT = 8;
  localparam int FULLASSOC_BIT = 9;
  localparam int RSVD_LSB    = 10;
  localparam int RSVD_W      = 4;
  localparam int SHARE_LSB   = 14;
  localparam int SHARE_W     = 12;
  localparam int CORES_LSB   = 26;
  localparam int CORES_W     = 6;

  // ****************************************
  // Second result word fields
  // ****************************************
  localparam int LINE_LSB    = 0;
  localparam int LINE_W      = 12;
  localparam int PART_LSB    = 12;
  localparam int PART_W      = 10;
  localparam int WAYS_LSB    = 22;
  localparam int WAYS_W      = 10;

  // ****************************************
  // Cache types
  // ****************************************
  typedef enum logic [4:0] {
    CT_NULL  = 5'h00,
    CT_DATA  = 5'h01,
    CT_INSTR = 5'h02,
    CT_UNIF  = 5'h03
  } cache_type_t;

  typedef enum logic [0:0] {
    ST_IDLE = 1'b0,
    ST_DONE = 1'b1
  } query_state_t;

  localparam int NUM_CACHES = 4;

endpackage : cache_enum_pkg

// file: verilog/cache_parameter_enumeration.sv
// Top of the cache parameter enumeration block
// What this block does
// (R1) Requester picks the cache through an index counting up from zero.
// (R2) First word: type in 4:0, level from one in 7:5.
// (R3) Bit 8 self-initialising, bit 9 fully associative.
// (R4) Bits 25:14 give sharing logical processor count, minus-one encoded.
// (R5) Bits 31:26 give cores per package minus one.
// (R6) Second word 11:0 gives line size in bytes minus one.
// (R7) Second word 21:12 gives line partitions minus one.
// (R8) Second word 31:22 gives ways minus one.
// (R9) Third word is sets minus one; size is product of all plus one.
// (R10) Leaves above 3 below 80000000 hidden while limit bit 22 set.
// (R11) Reserved first-word bits 13:10 and whole fourth word read zero.
module cache_parameter_enumeration #(
  parameter int NUM = cache_enum_pkg::NUM_CACHES
) (
  input  wire logic        CLK,
  input  wire logic        RESET_N,
  input  wire logic        CLK_EN,
  input  wire logic        QUERY_VALID,
  input  wire logic [31:0] QUERY_LEAF,
  input  wire logic [31:0] QUERY_INDEX,
  input  wire logic        MISC_WR,
  input  wire logic [31:0] MISC_WDATA,
  output logic             RESULT_VALID,
  output logic             RESULT_HIDDEN,
  output logic      [31:0] RESULT_A,
  output logic      [31:0] RESULT_B,
  output logic      [31:0] RESULT_C,
  output logic      [31:0] RESULT_D,
  output logic      [31:0] MISC_RDATA
);

  // The table holds four entries; counts outside 1..4 cannot be served
  if (NUM < 1 || NUM > 4) begin : g_bad_num
    $error("NUM must lie in 1..4");
  end

  // ****************************************
  // Leaf visibility control
  // ****************************************
  logic        limit_ff;
  logic        nxt_limit;
  wire  logic  leaf_in_range;
  wire  logic  leaf_hit;
  wire  logic  hidden;

  assign nxt_limit = MISC_WR ? MISC_WDATA[cache_enum_pkg::LEAF_LIMIT_BIT]
                             : limit_ff;
  assign leaf_in_range = (QUERY_LEAF > cache_enum_pkg::LIMIT_LEAF_LOW) &&
                         (QUERY_LEAF < cache_enum_pkg::LIMIT_LEAF_HIGH);
  assign hidden   = leaf_in_range && limit_ff; // see (R10)
  assign leaf_hit = (QUERY_LEAF == cache_enum_pkg::CACHE_LEAF) && !hidden;

  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      limit_ff <= cache_enum_pkg::LEAF_LIMIT_RESET;
    end else if (CLK_EN) begin
      limit_ff <= nxt_limit;
    end
  end

  // ****************************************
  // Descriptor lookup
  // ****************************************
  wire logic [31:0] rom_a;
  wire logic [31:0] rom_b;
  wire logic [31:0] rom_c;

  // Index is taken from the query itself, see (R1)
  cache_desc_rom #(.NUM(NUM)) u_rom (
    .index  (QUERY_INDEX),
    .word_a (rom_a),
    .word_b (rom_b),
    .word_c (rom_c)
  );

  // Hidden or foreign leaves answer all zero so software sees no cache
  wire logic [31:0] sel_a;
  wire logic [31:0] sel_b;
  wire logic [31:0] sel_c;
  assign sel_a = leaf_hit ? rom_a : 32'h0000_0000;
  assign sel_b = leaf_hit ? rom_b : 32'h0000_0000;
  assign sel_c = leaf_hit ? rom_c : 32'h0000_0000;

  // ****************************************
  // Result registers
  // ****************************************
  cache_enum_pkg::query_state_t state_ff;
  cache_enum_pkg::query_state_t nxt_state;

  always_comb begin
    case (state_ff)
      cache_enum_pkg::ST_IDLE: begin
        nxt_state = QUERY_VALID ? cache_enum_pkg::ST_DONE
                                : cache_enum_pkg::ST_IDLE;
      end
      default: begin
        nxt_state = QUERY_VALID ? cache_enum_pkg::ST_DONE
                                : cache_enum_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      state_ff      <= cache_enum_pkg::ST_IDLE;
      RESULT_VALID  <= 1'b0;
      RESULT_HIDDEN <= 1'b0;
      RESULT_A      <= 32'h0000_0000;
      RESULT_B      <= 32'h0000_0000;
      RESULT_C      <= 32'h0000_0000;
      RESULT_D      <= 32'h0000_0000;
      MISC_RDATA    <= 32'h0000_0000;
    end else if (CLK_EN) begin
      state_ff      <= nxt_state;
      RESULT_VALID  <= QUERY_VALID;
      MISC_RDATA    <= {9'h000, nxt_limit, 22'h000000};
      if (QUERY_VALID) begin
        RESULT_HIDDEN <= hidden;
        RESULT_A      <= sel_a;
        RESULT_B      <= sel_b;
        RESULT_C      <= sel_c;
        RESULT_D      <= 32'h0000_0000; // see (R11)
      end
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  property p_type_field;
    @(posedge CLK) disable iff (!RESET_N)
    RESULT_VALID |-> RESULT_A[4:0] <= 5'h03;
  endproperty
  a_type_field: assert property (p_type_field) // see (R2)
    else $error("Reserved cache type returned");

  property p_level_nonzero;
    @(posedge CLK) disable iff (!RESET_N)
    (RESULT_VALID && RESULT_A[4:0] != 5'h00) |-> RESULT_A[7:5] != 3'h0;
  endproperty
  a_level_nonzero: assert property (p_level_nonzero) // see (R2)
    else $error("Cache level zero for a real cache");

  property p_null_all_zero;
    @(posedge CLK) disable iff (!RESET_N)
    (RESULT_VALID && RESULT_A[4:0] == 5'h00) |->
      (RESULT_A == 32'h0 && RESULT_B == 32'h0 && RESULT_C == 32'h0);
  endproperty
  a_null_all_zero: assert property (p_null_all_zero) // see (R2)
    else $error("Null cache carries descriptor data");

  property p_rsvd_zero;
    @(posedge CLK) disable iff (!RESET_N)
    RESULT_VALID |-> (RESULT_A[13:10] == 4'h0 && RESULT_D == 32'h0);
  endproperty
  a_rsvd_zero: assert property (p_rsvd_zero) // see (R11)
    else $error("Reserved result bits nonzero");

  property p_hidden_zero;
    @(posedge CLK) disable iff (!RESET_N)
    (CLK_EN && QUERY_VALID && limit_ff && leaf_in_range) |=>
      (RESULT_HIDDEN && RESULT_A == 32'h0 && RESULT_B == 32'h0);
  endproperty
  a_hidden_zero: assert property (p_hidden_zero) // see (R10)
    else $error("Hidden leaf returned data");

  property p_index0_visible;
    @(posedge CLK) disable iff (!RESET_N)
    (CLK_EN && QUERY_VALID && !limit_ff && QUERY_INDEX == 32'h0 &&
     QUERY_LEAF == cache_enum_pkg::CACHE_LEAF) |=> RESULT_A[4:0] != 5'h00;
  endproperty
  a_index0_visible: assert property (p_index0_visible) // see (R1)
    else $error("Index zero gave no cache");

  property p_limit_write;
    @(posedge CLK) disable iff (!RESET_N)
    (CLK_EN && MISC_WR) |=> limit_ff == $past(MISC_WDATA[22]);
  endproperty
  a_limit_write: assert property (p_limit_write) // see (R10)
    else $error("Limit bit did not follow write");

  property p_fa_sets;
    @(posedge CLK) disable iff (!RESET_N)
    (RESULT_VALID && RESULT_A[9]) |-> RESULT_C == 32'h0;
  endproperty
  a_fa_sets: assert property (p_fa_sets) // see (R3)
    else $error("Fully associative cache with many sets");

  property p_valid_latency;
    @(posedge CLK) disable iff (!RESET_N)
    (CLK_EN && QUERY_VALID) |=> RESULT_VALID;
  endproperty
  a_valid_latency: assert property (p_valid_latency) // see (R1)
    else $error("Result not presented one cycle after query");

  property p_valid_drop;
    @(posedge CLK) disable iff (!RESET_N)
    (CLK_EN && !QUERY_VALID) |=> !RESULT_VALID;
  endproperty
  a_valid_drop: assert property (p_valid_drop) // see (R1)
    else $error("Result valid without a query");

  property p_freeze;
    @(posedge CLK) disable iff (!RESET_N)
    !CLK_EN |=> ($stable(RESULT_VALID) && $stable(RESULT_A) &&
                 $stable(limit_ff));
  endproperty
  a_freeze: assert property (p_freeze) // see (R1)
    else $error("State moved while clock enable was low");

  property p_result_hold;
    @(posedge CLK) disable iff (!RESET_N)
    (CLK_EN && !QUERY_VALID) |=>
      ($stable(RESULT_A) && $stable(RESULT_B) && $stable(RESULT_C));
  endproperty
  a_result_hold: assert property (p_result_hold) // see (R1)
    else $error("Result words changed without a query");

  property p_flag_hold;
    @(posedge CLK) disable iff (!RESET_N)
    (CLK_EN && !QUERY_VALID) |=>
      ($stable(RESULT_HIDDEN) && $stable(RESULT_D));
  endproperty
  a_flag_hold: assert property (p_flag_hold) // see (R10)
    else $error("Hidden flag changed without a query");

  property p_foreign_leaf;
    @(posedge CLK) disable iff (!RESET_N)
    (CLK_EN && QUERY_VALID && QUERY_LEAF != cache_enum_pkg::CACHE_LEAF) |=>
      (RESULT_A == 32'h0 && RESULT_B == 32'h0 && RESULT_C == 32'h0);
  endproperty
  a_foreign_leaf: assert property (p_foreign_leaf) // see (R2)
    else $error("Other leaf returned cache data");

  property p_index_past_end;
    @(posedge CLK) disable iff (!RESET_N)
    (CLK_EN && QUERY_VALID && QUERY_INDEX >= 32'(NUM)) |=>
      RESULT_A[4:0] == 5'h00;
  endproperty
  a_index_past_end: assert property (p_index_past_end) // see (R2)
    else $error("Index past the last cache did not end the list");

  property p_visible_leaf;
    @(posedge CLK) disable iff (!RESET_N)
    (CLK_EN && QUERY_VALID && !limit_ff && QUERY_INDEX < 32'(NUM) &&
     QUERY_LEAF == cache_enum_pkg::CACHE_LEAF) |=>
      (!RESULT_HIDDEN && RESULT_A[4:0] != 5'h00);
  endproperty
  a_visible_leaf: assert property (p_visible_leaf) // see (R10)
    else $error("Visible leaf returned no cache");

  property p_hidden_flag_clear;
    @(posedge CLK) disable iff (!RESET_N)
    (CLK_EN && QUERY_VALID && !limit_ff) |=> !RESULT_HIDDEN;
  endproperty
  a_hidden_flag_clear: assert property (p_hidden_flag_clear) // see (R10)
    else $error("Leaf hidden while limit bit clear");

  property p_hidden_range;
    @(posedge CLK) disable iff (!RESET_N)
    (CLK_EN && QUERY_VALID && !leaf_in_range) |=> !RESULT_HIDDEN;
  endproperty
  a_hidden_range: assert property (p_hidden_range) // see (R10)
    else $error("Leaf outside the limited range was hidden");

  property p_hidden_rest_zero;
    @(posedge CLK) disable iff (!RESET_N)
    (CLK_EN && QUERY_VALID && hidden) |=>
      (RESULT_C == 32'h0 && RESULT_D == 32'h0);
  endproperty
  a_hidden_rest_zero: assert property (p_hidden_rest_zero) // see (R10)
    else $error("Hidden leaf returned set count");

  property p_hidden_null;
    @(posedge CLK) disable iff (!RESET_N)
    (RESULT_VALID && RESULT_HIDDEN) |-> RESULT_A[4:0] == 5'h00;
  endproperty
  a_hidden_null: assert property (p_hidden_null) // see (R10)
    else $error("Hidden result carries a cache type");

  property p_limit_hold;
    @(posedge CLK) disable iff (!RESET_N)
    (CLK_EN && !MISC_WR) |=> $stable(limit_ff);
  endproperty
  a_limit_hold: assert property (p_limit_hold) // see (R10)
    else $error("Limit bit changed without a write");

  property p_misc_mirror;
    @(posedge CLK) disable iff (!RESET_N)
    CLK_EN |=> MISC_RDATA == {9'h000, limit_ff, 22'h000000};
  endproperty
  a_misc_mirror: assert property (p_misc_mirror) // see (R10)
    else $error("Control readback differs from limit bit");

  property p_state_tracks;
    @(posedge CLK) disable iff (!RESET_N)
    (state_ff == cache_enum_pkg::ST_DONE) == RESULT_VALID;
  endproperty
  a_state_tracks: assert property (p_state_tracks) // see (R1)
    else $error("Query state and result valid disagree");

endmodule // cache_parameter_enumeration
